// ---- logic/spc_frame_engine.sv ----
/*
  Frame engine: bit timing, transmit and receive shifters for the four serial modes.
  Assumes rxd_level and ovf_tick are already synchronised to pclk.
*/
`timescale 1ns/1ns
module spc_frame_engine (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // line, synchronised
  input wire logic rxd_level,
  input wire logic ovf_tick,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  // control side
  spc_frame_if.engine fif
);
  import spc_pkg::*;
  typedef enum logic [2:0] {
    SPC_RX_IDLE = 3'b001,
    SPC_RX_SHIFT = 3'b010,
    SPC_RX_UART = 3'b100
  } spc_rx_state_e;
  spc_rx_state_e rx_state_reg, rx_state_next;
  logic [4:0] div_reg, div_next, lim;
  logic [3:0] tx_os_reg, tx_os_next, tx_cnt_reg, tx_cnt_next, frame_bits;
  logic [3:0] rx_os_reg, rx_os_next, rx_cnt_reg, rx_cnt_next;
  logic [10:0] tx_sh_reg, tx_sh_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic tx_busy_reg, tx_busy_next, tx_done_reg, tx_done_next;
  logic rx_done_reg, rx_done_next, rx_ninth_reg, rx_ninth_next, rx_stop_reg, rx_stop_next;
  logic txd_reg, txd_next, rxd_out_reg, rxd_out_next, rxd_oe_reg, rxd_oe_next;
  logic rxd_prev_reg, shift_mode, nine, src, bit_tick, os_tick;

  always_comb begin
    shift_mode = (fif.mode == SPC_MODE_SHIFT);
    nine = fif.mode[1];
    frame_bits = nine ? FRAME9_BITS : FRAME8_BITS;
    // fixed rate 9-bit mode counts pclk, variable modes count timer overflows
    unique case (fif.mode)
      SPC_MODE_SHIFT: begin
        src = 1'b1;
        lim = SHIFT_DIV - 5'h01;
      end
      SPC_MODE_FIXED9: begin
        src = 1'b1;
        lim = (fif.baud_double ? FIXED_DIV_FAST : FIXED_DIV_SLOW) - 5'h01;
      end
      default: begin
        src = ovf_tick;
        lim = (fif.baud_double ? VAR_DIV_FAST : VAR_DIV_SLOW) - 5'h01;
      end
    endcase
    div_next = src ? ((div_reg >= lim) ? 5'h00 : div_reg + 5'h01) : div_reg;
    // restart the bit clock so the first mode 0 bit gets a full low and high phase
    if (shift_mode && fif.tx_start) begin
      div_next = 5'h00;
    end
    bit_tick = shift_mode && (div_reg >= lim);
    os_tick = !shift_mode && src && (div_reg >= lim);
  end

  always_comb begin
    tx_sh_next = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_os_next = tx_os_reg;
    tx_busy_next = tx_busy_reg;
    tx_done_next = 1'b0;
    if (fif.tx_start) begin
      tx_busy_next = 1'b1;
      tx_cnt_next = 4'h0;
      tx_os_next = 4'h0;
      tx_sh_next = shift_mode ? {3'b111, fif.tx_data}
        : {1'b1, (nine ? fif.tx_ninth : 1'b1), fif.tx_data, 1'b0};
    end else if (tx_busy_reg) begin
      if (os_tick) begin
        tx_os_next = tx_os_reg + 4'h1;
      end
      if (bit_tick || (os_tick && tx_os_reg == OS_LAST)) begin
        tx_sh_next = {1'b1, tx_sh_reg[10:1]};
        tx_cnt_next = tx_cnt_reg + 4'h1;
        if (shift_mode && tx_cnt_next == SHIFT_BITS) begin
          tx_done_next = 1'b1;
          tx_busy_next = 1'b0;
        end
        if (!shift_mode && tx_cnt_next == frame_bits - 4'h1) begin
          tx_done_next = 1'b1;
        end
        if (!shift_mode && tx_cnt_next == frame_bits) begin
          tx_busy_next = 1'b0;
        end
      end
    end
  end

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_os_next = rx_os_reg;
    rx_done_next = 1'b0;
    rx_ninth_next = rx_ninth_reg;
    rx_stop_next = rx_stop_reg;
    unique case (rx_state_reg)
      SPC_RX_IDLE: begin
        rx_cnt_next = 4'h0;
        rx_os_next = 4'h0;
        if (fif.ren && shift_mode && !fif.ri && !tx_busy_reg && !fif.tx_start) begin
          rx_state_next = SPC_RX_SHIFT;
        end else if (fif.ren && !shift_mode && rxd_prev_reg && !rxd_level) begin
          rx_state_next = SPC_RX_UART;
        end
      end
      SPC_RX_SHIFT: begin
        if (!fif.ren || !shift_mode) begin
          rx_state_next = SPC_RX_IDLE;
        end else if (bit_tick) begin
          rx_sh_next = {rxd_level, rx_sh_reg[7:1]};
          rx_cnt_next = rx_cnt_reg + 4'h1;
          if (rx_cnt_next == SHIFT_BITS) begin
            rx_done_next = 1'b1;
            rx_stop_next = 1'b1;
            rx_state_next = SPC_RX_IDLE;
          end
        end
      end
      SPC_RX_UART: begin
        if (!fif.ren || shift_mode) begin
          rx_state_next = SPC_RX_IDLE;
        end else if (os_tick) begin
          rx_os_next = rx_os_reg + 4'h1;
          if (rx_os_reg == SAMPLE_POINT) begin
            rx_cnt_next = rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == 4'h0) begin
              // a glitch rather than a start bit
              if (rxd_level) begin
                rx_state_next = SPC_RX_IDLE;
              end
            end else if (rx_cnt_reg <= SHIFT_BITS) begin
              rx_sh_next = {rxd_level, rx_sh_reg[7:1]};
            end else if (nine && rx_cnt_reg == SHIFT_BITS + 4'h1) begin
              rx_ninth_next = rxd_level;
            end else begin
              rx_stop_next = rxd_level;
              rx_ninth_next = nine ? rx_ninth_reg : rxd_level;
              rx_done_next = 1'b1;
              rx_state_next = SPC_RX_IDLE;
            end
          end
        end
      end
      default: rx_state_next = SPC_RX_IDLE;
    endcase
  end

  always_comb begin
    // mode 0: txd carries the shift clock, rxd the data
    txd_next = shift_mode
      ? !((tx_busy_reg || rx_state_reg == SPC_RX_SHIFT) && div_reg < SHIFT_LOW)
      : (tx_busy_reg ? tx_sh_reg[0] : 1'b1);
    rxd_oe_next = shift_mode && tx_busy_reg;
    rxd_out_next = rxd_oe_next ? tx_sh_reg[0] : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 5'h00;
      tx_sh_reg <= 11'h7FF;
      tx_cnt_reg <= 4'h0;
      tx_os_reg <= 4'h0;
      tx_busy_reg <= 1'b0;
      tx_done_reg <= 1'b0;
      rx_state_reg <= SPC_RX_IDLE;
      rx_sh_reg <= 8'h00;
      rx_cnt_reg <= 4'h0;
      rx_os_reg <= 4'h0;
      rx_done_reg <= 1'b0;
      rx_ninth_reg <= 1'b0;
      rx_stop_reg <= 1'b0;
      rxd_prev_reg <= 1'b1;
      txd_reg <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg <= 1'b0;
    end else if (ce) begin
      div_reg <= div_next;
      tx_sh_reg <= tx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_os_reg <= tx_os_next;
      tx_busy_reg <= tx_busy_next;
      tx_done_reg <= tx_done_next;
      rx_state_reg <= rx_state_next;
      rx_sh_reg <= rx_sh_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_os_reg <= rx_os_next;
      rx_done_reg <= rx_done_next;
      rx_ninth_reg <= rx_ninth_next;
      rx_stop_reg <= rx_stop_next;
      rxd_prev_reg <= rxd_level;
      txd_reg <= txd_next;
      rxd_out_reg <= rxd_out_next;
      rxd_oe_reg <= rxd_oe_next;
    end
  end

  assign fif.tx_done = tx_done_reg;
  assign fif.tx_busy = tx_busy_reg;
  assign fif.rx_done = rx_done_reg;
  assign fif.rx_data = rx_sh_reg;
  assign fif.rx_ninth = rx_ninth_reg;
  assign fif.rx_stop = rx_stop_reg;
  assign txd = txd_reg;
  assign rxd_out = rxd_out_reg;
  assign rxd_oe = rxd_oe_reg;
endmodule

// ---- logic/spc_frame_if.sv ----
/*
  Bundle between the register side and the frame engine of the serial port.
  Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ns
interface spc_frame_if;
  import spc_pkg::*;
  spc_mode_e mode;
  logic baud_double;
  logic ren;
  logic ri;
  logic tx_start;
  logic [7:0] tx_data;
  logic tx_ninth;
  logic tx_done;
  logic tx_busy;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_stop;
  modport ctrl (output mode, baud_double, ren, ri, tx_start, tx_data, tx_ninth,
    input tx_done, tx_busy, rx_done, rx_data, rx_ninth, rx_stop);
  modport engine (input mode, baud_double, ren, ri, tx_start, tx_data, tx_ninth,
    output tx_done, tx_busy, rx_done, rx_data, rx_ninth, rx_stop);
endinterface

// ---- logic/spc_pkg.sv ----
/*
  Shared constants of the serial port control block: register byte offsets, bit positions,
  reset values, mode codes and bit timing ratios.
  Assumes a 32-bit APB bus with 12-bit byte addresses; timing is in pclk cycles, timer overflows or oversample ticks.
*/
package spc_pkg;
  // register map (byte addresses)
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h098;
  localparam logic [11:0] BUF_OFS = 12'h09C;
  localparam logic [11:0] AUX_OFS = 12'h0A0;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h0A4;
  localparam logic [11:0] IRQ_EN_OFS = 12'h0A8;
  localparam logic [11:0] IRQ_CLR_OFS = 12'h0AC;
  // serial_port_control bit positions
  localparam int CTRL_MODE_HIGH = 7;
  localparam int CTRL_MODE_LOW = 6;
  localparam int CTRL_MPE = 5;
  localparam int CTRL_REN = 4;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_RB8 = 2;
  localparam int CTRL_TI = 1;
  localparam int CTRL_RI = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // power_control_register bits
  localparam int AUX_VIEW = 7;
  localparam int AUX_BAUD_DBL = 6;
  localparam logic [1:0] AUX_RESET = 2'h0;
  // interrupt status / enable / clear layout
  localparam int IRQ_W = 3;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_FE = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // serial modes
  typedef enum logic [1:0] {
    SPC_MODE_SHIFT = 2'h0,
    SPC_MODE_UART8 = 2'h1,
    SPC_MODE_FIXED9 = 2'h2,
    SPC_MODE_VAR9 = 2'h3
  } spc_mode_e;
  // bit timing, in pclk cycles, timer overflows or oversample ticks
  localparam logic [4:0] SHIFT_DIV = 5'h06;
  localparam logic [4:0] SHIFT_LOW = 5'h03;
  localparam logic [4:0] OVERSAMPLE = 5'h10;
  localparam logic [4:0] FIXED_DIV_SLOW = 5'h02;
  localparam logic [4:0] FIXED_DIV_FAST = 5'h01;
  localparam logic [4:0] VAR_DIV_SLOW = 5'h02;
  localparam logic [4:0] VAR_DIV_FAST = 5'h01;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] SHIFT_BITS = 4'h8;
  localparam logic [3:0] FRAME8_BITS = 4'hA;
  localparam logic [3:0] FRAME9_BITS = 4'hB;
endpackage

// ---- logic/spc_serial_port.sv ----
/*
  Serial port control and status block: APB register file, flag logic, interrupt,
  pin synchronisers and the frame engine.
  Assumes the timer overflow arrives as a level that toggles high once per overflow
  and that the rxd pin may change at any time relative to pclk.
*/
// Added by the designer: register access over APB.
// Overview of operation
// - Two mode bits pick shift register, 8-bit UART, fixed 9-bit or variable 9-bit.
// - Control bit 7 is mode_bit_high or framing_error_flag, chosen by view select.
// - Bad stop bit sets framing_error_flag; only a software write clears it.
// - In 9-bit modes with multiprocessor enable, ninth bit 0 leaves receive flag clear.
// - In 8-bit UART with multiprocessor enable, receive flag needs a valid stop bit.
// - Reception happens only while receive_enable is set.
// - Received ninth bit: 9-bit modes take ninth bit; 8-bit without filtering takes stop.
// - Transmit flag sets after eighth bit in mode 0, at stop start otherwise.
// - Receive flag sets after eighth bit in mode 0, mid stop bit otherwise.
// - Mode 0 runs at clock/6; fixed 9-bit mode at clock/32 or clock/16.
// - Mode 0 reception starts when flag clear, enabled and not transmitting; others on start bit.
// - Any serial_buffer write starts transmission; 9-bit modes send transmit_ninth_bit.
`timescale 1ns/1ns
module spc_serial_port (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spc_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  // baud source from the timer block
  input wire logic timer_ovf,
  // interrupt
  output logic irq
);
  import spc_pkg::*;

  spc_frame_if fif ();

  logic [2:0] rxd_sync_reg, ovf_sync_reg;
  logic rxd_level_reg, rxd_level_next, ovf_level_reg, ovf_level_next, ovf_tick_reg, ovf_tick_next;
  logic mode_high_reg, mode_low_reg, mpe_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg, fe_reg;
  logic mode_high_next, mode_low_next, mpe_next, ren_next, tb8_next, rb8_next;
  logic ti_next, ri_next, fe_next;
  logic view_reg, view_next, bdbl_reg, bdbl_next;
  logic [7:0] rbuf_reg, rbuf_next, tdata_reg, tdata_next;
  logic tstart_reg, tstart_next;
  logic [IRQ_W-1:0] istat_reg, istat_next, ien_reg, ien_next, ievt;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic wr, ctrl_wr, buf_wr, rx_ok, rb8_load, fe_evt;
  logic [7:0] ctrl_view;

  function automatic logic spc_hit(input logic [APB_ADDR_W-1:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic spc_known(input logic [APB_ADDR_W-1:0] a);
    return spc_hit(a, CTRL_OFS) || spc_hit(a, BUF_OFS) || spc_hit(a, AUX_OFS)
      || spc_hit(a, IRQ_STAT_OFS) || spc_hit(a, IRQ_EN_OFS) || spc_hit(a, IRQ_CLR_OFS);
  endfunction

  // pin synchronisers: a change counts once stages two and three agree
  always_comb begin
    rxd_level_next = (rxd_sync_reg[1] == rxd_sync_reg[2]) ? rxd_sync_reg[2] : rxd_level_reg;
    ovf_level_next = (ovf_sync_reg[1] == ovf_sync_reg[2]) ? ovf_sync_reg[2] : ovf_level_reg;
    ovf_tick_next = ovf_level_next && !ovf_level_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_sync_reg <= 3'h7;
      ovf_sync_reg <= 3'h0;
      rxd_level_reg <= 1'b1;
      ovf_level_reg <= 1'b0;
      ovf_tick_reg <= 1'b0;
    end else if (ce) begin
      rxd_sync_reg <= {rxd_sync_reg[1:0], rxd_in};
      ovf_sync_reg <= {ovf_sync_reg[1:0], timer_ovf};
      rxd_level_reg <= rxd_level_next;
      ovf_level_reg <= ovf_level_next;
      ovf_tick_reg <= ovf_tick_next;
    end
  end

  // apb: setup cycle registers the answer, access phase completes in one cycle
  always_comb begin
    wr = psel && penable && pready_reg && pwrite;
    ctrl_wr = wr && spc_hit(paddr, CTRL_OFS);
    buf_wr = wr && spc_hit(paddr, BUF_OFS);
    ctrl_view = {(view_reg ? fe_reg : mode_high_reg), mode_low_reg, mpe_reg, ren_reg,
      tb8_reg, rb8_reg, ti_reg, ri_reg};
    pready_next = psel && !penable;
    pslverr_next = psel && !penable && !spc_known(paddr);
    prdata_next = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (spc_hit(paddr, CTRL_OFS)) begin
        prdata_next[7:0] = ctrl_view;
      end else if (spc_hit(paddr, BUF_OFS)) begin
        prdata_next[7:0] = rbuf_reg;
      end else if (spc_hit(paddr, AUX_OFS)) begin
        prdata_next[AUX_VIEW] = view_reg;
        prdata_next[AUX_BAUD_DBL] = bdbl_reg;
      end else if (spc_hit(paddr, IRQ_STAT_OFS)) begin
        prdata_next[IRQ_W-1:0] = istat_reg;
      end else if (spc_hit(paddr, IRQ_EN_OFS)) begin
        prdata_next[IRQ_W-1:0] = ien_reg;
      end
    end
  end

  // receive filtering and flag events
  always_comb begin
    unique case (fif.mode)
      SPC_MODE_SHIFT: rx_ok = fif.rx_done;
      SPC_MODE_UART8: rx_ok = fif.rx_done && (!mpe_reg || fif.rx_stop);
      default: rx_ok = fif.rx_done && (!mpe_reg || fif.rx_ninth);
    endcase
    rb8_load = fif.mode[1] ? rx_ok : (fif.rx_done && fif.mode == SPC_MODE_UART8 && !mpe_reg);
    fe_evt = fif.rx_done && fif.mode != SPC_MODE_SHIFT && !fif.rx_stop;
    ievt = '0;
    ievt[IRQ_RX] = rx_ok;
    ievt[IRQ_TX] = fif.tx_done;
    ievt[IRQ_FE] = fe_evt;
  end

  // control state; hardware sets win over a software write in the same cycle
  always_comb begin
    mode_high_next = mode_high_reg;
    mode_low_next = mode_low_reg;
    mpe_next = mpe_reg;
    ren_next = ren_reg;
    tb8_next = tb8_reg;
    rb8_next = rb8_reg;
    ti_next = ti_reg;
    ri_next = ri_reg;
    fe_next = fe_reg;
    view_next = view_reg;
    bdbl_next = bdbl_reg;
    rbuf_next = rbuf_reg;
    tdata_next = tdata_reg;
    tstart_next = buf_wr;
    istat_next = istat_reg;
    ien_next = ien_reg;
    if (ctrl_wr) begin
      if (view_reg) begin
        fe_next = pwdata[CTRL_MODE_HIGH];
      end else begin
        mode_high_next = pwdata[CTRL_MODE_HIGH];
      end
      mode_low_next = pwdata[CTRL_MODE_LOW];
      mpe_next = pwdata[CTRL_MPE];
      ren_next = pwdata[CTRL_REN];
      tb8_next = pwdata[CTRL_TB8];
      rb8_next = pwdata[CTRL_RB8];
      ti_next = pwdata[CTRL_TI];
      ri_next = pwdata[CTRL_RI];
    end
    if (buf_wr) begin
      tdata_next = pwdata[7:0];
    end
    if (wr && spc_hit(paddr, AUX_OFS)) begin
      view_next = pwdata[AUX_VIEW];
      bdbl_next = pwdata[AUX_BAUD_DBL];
    end
    if (wr && spc_hit(paddr, IRQ_EN_OFS)) begin
      ien_next = pwdata[IRQ_W-1:0];
    end
    if (wr && spc_hit(paddr, IRQ_CLR_OFS)) begin
      istat_next = istat_reg & ~pwdata[IRQ_W-1:0];
    end
    istat_next = istat_next | ievt;
    if (fe_evt) begin
      fe_next = 1'b1;
    end
    if (fif.tx_done) begin
      ti_next = 1'b1;
    end
    if (rx_ok) begin
      ri_next = 1'b1;
      rbuf_next = fif.rx_data;
    end
    if (rb8_load) begin
      rb8_next = fif.rx_ninth;
    end
    irq_next = |(istat_next & ien_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mode_high_reg, mode_low_reg, mpe_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg}
        <= CTRL_RESET;
      fe_reg <= 1'b0;
      {view_reg, bdbl_reg} <= AUX_RESET;
      rbuf_reg <= 8'h00;
      tdata_reg <= 8'h00;
      tstart_reg <= 1'b0;
      istat_reg <= IRQ_RESET;
      ien_reg <= IRQ_RESET;
      irq_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      {mode_high_reg, mode_low_reg, mpe_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg}
        <= {mode_high_next, mode_low_next, mpe_next, ren_next, tb8_next, rb8_next,
        ti_next, ri_next};
      fe_reg <= fe_next;
      {view_reg, bdbl_reg} <= {view_next, bdbl_next};
      rbuf_reg <= rbuf_next;
      tdata_reg <= tdata_next;
      tstart_reg <= tstart_next;
      istat_reg <= istat_next;
      ien_reg <= ien_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign fif.mode = spc_mode_e'({mode_high_reg, mode_low_reg});
  assign fif.baud_double = bdbl_reg;
  assign fif.ren = ren_reg;
  assign fif.ri = ri_reg;
  assign fif.tx_start = tstart_reg;
  assign fif.tx_data = tdata_reg;
  assign fif.tx_ninth = tb8_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  spc_frame_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .rxd_level(rxd_level_reg),
    .ovf_tick(ovf_tick_reg),
    .rxd_out(rxd_out),
    .rxd_oe(rxd_oe),
    .txd(txd),
    .fif(fif.engine)
  );

  a_fe_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && fe_evt |=> fe_reg) else $error("framing error not flagged");
  a_fe_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    fe_reg && !ctrl_wr |=> fe_reg) else $error("framing error cleared by hardware");
  a_ri_ninth_filter: assert property (@(posedge pclk) disable iff (!presetn)
    ce && fif.rx_done && fif.mode[1] && mpe_reg && !fif.rx_ninth && !ri_reg && !ctrl_wr
    |=> !ri_reg) else $error("address filter let data frame through");
  a_ri_stop_filter: assert property (@(posedge pclk) disable iff (!presetn)
    ce && fif.rx_done && fif.mode == SPC_MODE_UART8 && mpe_reg && !fif.rx_stop && !ri_reg
    && !ctrl_wr |=> !ri_reg) else $error("receive flag without valid stop");
  a_rx_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    !ren_reg && $past(!ren_reg) |-> !fif.rx_done) else $error("reception while disabled");
  a_rb8_load: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rb8_load |=> rb8_reg == $past(fif.rx_ninth)) else $error("ninth bit not loaded");
  a_ti_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && fif.tx_done |=> ti_reg && ctrl_view[CTRL_TI]) else $error("transmit flag missed");
  a_ri_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rx_ok |=> ri_reg && rbuf_reg == $past(fif.rx_data)) else $error("receive flag missed");
  a_tx_start: assert property (@(posedge pclk) disable iff (!presetn)
    ce && buf_wr |=> tstart_reg ##1 (!ce || fif.tx_busy)) else $error("write did not start send");
  a_tx_load: assert property (@(posedge pclk) disable iff (!presetn)
    ce && buf_wr |=> fif.tx_data == $past(pwdata[7:0]))
    else $error("transmit data not loaded");
  // flags are sticky: only a control write may take them down
  a_ti_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ti_reg && !ctrl_wr |=> ti_reg)
    else $error("transmit flag cleared by hardware");
  a_ri_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ri_reg && !ctrl_wr |=> ri_reg)
    else $error("receive flag cleared by hardware");
  a_mode_kept: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && view_reg |=> mode_high_reg == $past(mode_high_reg))
    else $error("mode bit written while error view selected");
  a_rb8_shift: assert property (@(posedge pclk) disable iff (!presetn)
    fif.mode == SPC_MODE_SHIFT && !ctrl_wr |=> rb8_reg == $past(rb8_reg))
    else $error("ninth bit changed in shift mode");
  // bus side: ready lasts one cycle since the master is already in its access phase
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    ce && pready |=> !pready)
    else $error("ready held past one cycle");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> irq == |(istat_reg & ien_reg))
    else $error("interrupt level disagrees with status");
endmodule

// ---- testbench/spc_peer.sv ----
/*
  Remote serial peer: sends frames at a given bit length, captures mode 2 frames at 32 clocks a bit.
  Assumes baud_double_select is 0 and txd idles high.
*/
`timescale 1ns/1ns
module spc_peer (
  // clock
  input wire logic pclk,
  // line
  input wire logic txd,
  output logic rxd
);
  logic [8:0] got;
  initial rxd = 1'h1;
  // start, 9 data lsb first, stop; a stop of 0 is a deliberate framing fault
  task automatic send(input logic [8:0] v, input logic stop, input int bt);
    rxd <= 1'h0;
    repeat (bt) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      rxd <= v[i];
      repeat (bt) @(posedge pclk);
    end
    rxd <= stop;
    repeat (bt) @(posedge pclk);
    // idle gap so the next start edge is clean
    rxd <= 1'h1;
    repeat (bt) @(posedge pclk);
  endtask
  // sample mid-cell, so a wrong bit rate shows as wrong data
  always begin
    @(negedge txd);
    repeat (16) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (32) @(posedge pclk);
      got[i] = txd;
    end
  end
endmodule

// ---- testbench/spc_serial_port_test.sv ----
/*
  Bench of the serial port block: APB tasks, flag, frame and interrupt checks.
  Assumes the peer frames at the bit length it is given; APB waits as long as the slave needs.
*/
`timescale 1ns/1ns
module spc_serial_port_test;
  import spc_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic timer_ovf = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, rxd_in, txd, irq, e, rxd_out, rxd_oe;
  logic [7:0] m0 = 8'h5A;
  time t = 0;
  int n_mismatch = 0, checks = 0;
  always #5 pclk = ~pclk;
  // timer overflow at the link rate, unrelated to pclk phase
  always begin
    #62 timer_ovf = 1'h1;
    #63 timer_ovf = 1'h0;
  end
  spc_serial_port spc_serial_port_i (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd(txd), .timer_ovf(timer_ovf), .irq(irq));
  spc_peer spc_peer_i (.pclk(pclk), .txd(txd), .rxd(rxd_in));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // the slave's pready ends this wait; the watchdog ends it only if pready never comes
    do @(posedge pclk); while (pready !== 1'h1);
    chk(pready, 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic poll(input int b);
    r = 32'h0;
    while (r[b] !== 1'h1) apb(1'h0, CTRL_OFS, 32'h0);
  endtask
  task final_report;
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // whole run is about 12000 cycles; this leaves ample margin
  initial begin
    #300000;
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r, 32'h0);
    apb(1'h0, 12'hFF0, 32'h0);
    chk(e, 1'h1);
    // mode 2, receive on, ninth transmit bit 1
    apb(1'h1, CTRL_OFS, 32'h98);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r, 32'h98);
    apb(1'h1, IRQ_EN_OFS, 32'h7);
    apb(1'h1, BUF_OFS, 32'hA5);
    poll(CTRL_TI);
    chk(r[CTRL_TI], 1'h1);
    chk(spc_peer_i.got, 9'h1A5);
    chk(irq, 1'h1);
    apb(1'h1, IRQ_CLR_OFS, 32'h7);
    apb(1'h1, CTRL_OFS, 32'h98);
    repeat (3) @(posedge pclk);
    chk(irq, 1'h0);
    spc_peer_i.send(9'h13C, 1'h1, 32);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r, 32'h9D);
    apb(1'h0, BUF_OFS, 32'h0);
    chk(r, 32'h3C);
    // address filter on: a frame with ninth bit 0 must be dropped
    apb(1'h1, CTRL_OFS, 32'hB8);
    spc_peer_i.send(9'h055, 1'h1, 32);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r[CTRL_RI], 1'h0);
    apb(1'h1, AUX_OFS, 32'h80);
    apb(1'h1, CTRL_OFS, 32'h18);
    spc_peer_i.send(9'h1FF, 1'h0, 32);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r[7], 1'h1);
    spc_peer_i.send(9'h1AA, 1'h1, 32);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r[7], 1'h1);
    apb(1'h1, CTRL_OFS, 32'h18);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r[7], 1'h0);
    chk(irq, 1'h1);
    apb(1'h1, IRQ_EN_OFS, 32'h0);
    repeat (3) @(posedge pclk);
    chk(irq, 1'h0);
    // receive off: a good frame must not raise the receive flag
    apb(1'h1, CTRL_OFS, 32'h08);
    spc_peer_i.send(9'h1AA, 1'h1, 32);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r[CTRL_RI], 1'h0);
    // mode 0: data leaves on rxd_out, taken at each rising shift clock on txd
    apb(1'h1, AUX_OFS, 32'h0);
    apb(1'h1, CTRL_OFS, 32'h0);
    apb(1'h1, BUF_OFS, 32'h5A);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      chk({rxd_oe, rxd_out}, {1'h1, m0[i]});
      if (i > 0) chk(32'($time - t), 32'h3C);
      t = $time;
    end
    poll(CTRL_TI);
    chk(r[CTRL_TI], 1'h1);
    // mode 1 at the timer rate: the tenth line bit is the stop bit
    apb(1'h1, CTRL_OFS, 32'h70);
    spc_peer_i.send(9'h0AA, 1'h1, 400);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r[CTRL_RI], 1'h0);
    apb(1'h1, CTRL_OFS, 32'h50);
    spc_peer_i.send(9'h155, 1'h1, 400);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(r, 32'h55);
    final_report;
  end
endmodule
